// File: src/qdac_pkg.sv
// Shared constants and types for the quad converter control block
package qdac_pkg;

  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS = 12;
  localparam logic [3:0] WORD_LAST = 4'hc;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam int unsigned TYPE_HI = 11;
  localparam int unsigned TYPE_LO = 10;
  localparam logic [1:0] TYPE_DATA = 2'h1;
  localparam logic [1:0] TYPE_CTRL = 2'h2;
  localparam int unsigned ADDR_HI = 9;
  localparam int unsigned ADDR_LO = 8;
  localparam int unsigned CODE_HI = 7;
  localparam int unsigned CODE_LO = 0;

  // ----------------------------------------------------------------
  // Control word fields (dac_control_word, ten active bits)
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_BITS = 10;
  localparam int unsigned CTRL_MODE_POS = 9;
  localparam int unsigned CTRL_RNG_HI = 8;
  localparam int unsigned CTRL_RNG_LO = 5;
  localparam int unsigned CTRL_SI_HI = 4;
  localparam int unsigned CTRL_SI_LO = 1;
  localparam int unsigned CTRL_ACT_POS = 0;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned CODE_BITS = 8;
  localparam logic MODE_RST = 1'b0;
  localparam logic [3:0] RNG_RST = 4'hf;
  localparam logic [3:0] SI_RST = 4'h0;
  localparam logic ACT_RST = 1'b0;
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic [11:0] SHIFT_RST = 12'h000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    CHAN_A = 2'b00,
    CHAN_B = 2'b01,
    CHAN_C = 2'b10,
    CHAN_D = 2'b11
  } qdac_chan_t;

  typedef enum logic
  {
    MODE_DOUBLE = 1'b0,
    MODE_SINGLE = 1'b1
  } qdac_mode_t;

  // Channel address to one-hot select
  function automatic logic [3:0] qdac_chan_dec(input logic [1:0] addr);
    logic [3:0] sel;
    sel = 4'h0;
    case (addr)
      CHAN_A: sel = 4'h1;
      CHAN_B: sel = 4'h2;
      CHAN_C: sel = 4'h4;
      CHAN_D: sel = 4'h8;
      default: sel = 4'h0;
    endcase
    return sel;
  endfunction

endpackage

// File: src/qdac_hold_buf.sv
// Per-channel holding buffers and output code registers
`timescale 1ns/1ps
`default_nettype none

module qdac_hold_buf
  import qdac_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Holding buffer write
  input wire logic wr_en_in,
  input wire logic [1:0] wr_chan_in,
  input wire logic [7:0] wr_code_in,
  // Output update
  input wire logic update_in,
  // Output codes
  output logic [7:0] code_a_out,
  output logic [7:0] code_b_out,
  output logic [7:0] code_c_out,
  output logic [7:0] code_d_out
);

  logic [7:0] hold_r [NUM_CHAN];
  logic [7:0] out_r [NUM_CHAN];
  logic [3:0] wr_sel;

  assign wr_sel = wr_en_in ? qdac_chan_dec(wr_chan_in) : 4'h0;

  // ----------------------------------------------------------------
  // Holding and output registers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++)
    begin : g_chan
      // A later block to the same channel overwrites the earlier one
      always_ff @(posedge mclk_in)
      begin
        if (reset_in)
          hold_r[gi] <= CODE_RST;
        else if (wr_sel[gi])
          hold_r[gi] <= wr_code_in;
      end

      // All channels move together on the update event
      always_ff @(posedge mclk_in)
      begin
        if (reset_in)
          out_r[gi] <= CODE_RST;
        else if (update_in)
          out_r[gi] <= hold_r[gi];
      end
    end
  endgenerate

  assign code_a_out = out_r[0];
  assign code_b_out = out_r[1];
  assign code_c_out = out_r[2];
  assign code_d_out = out_r[3];

endmodule // qdac_hold_buf

`default_nettype wire

// File: src/qdac_ctrl.sv
// Serial word receiver, control register, update and shutdown logic
`timescale 1ns/1ps
`default_nettype none

module qdac_ctrl
  import qdac_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Serial link pins
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic strobe_in,
  // Hardware activate pin
  input wire logic hw_activate_pin_in,
  // Converter output codes
  output logic [7:0] output_channel_a_out,
  output logic [7:0] output_channel_b_out,
  output logic [7:0] output_channel_c_out,
  output logic [7:0] output_channel_d_out,
  // Applied gain per channel, bit 0 is channel A
  output logic [3:0] gain_double_out,
  // Channel active per channel, bit 0 is channel A
  output logic [3:0] chan_active_out,
  // Control register state
  output logic mode_single_out,
  output logic [9:0] control_word_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sclk_s1_r;
  logic sclk_s2_r;
  logic sclk_d_r;
  logic sdat_s1_r;
  logic sdat_s2_r;
  logic stb_s1_r;
  logic stb_s2_r;
  logic stb_d_r;

  // Serial clock pin
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
    end
    else
    begin
      sclk_s1_r <= ser_clk_in;
      sclk_s2_r <= sclk_s1_r;
    end
  end

  // Serial data pin
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      sdat_s1_r <= 1'b0;
      sdat_s2_r <= 1'b0;
    end
    else
    begin
      sdat_s1_r <= ser_data_in;
      sdat_s2_r <= sdat_s1_r;
    end
  end

  // Strobe pin
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      stb_s1_r <= 1'b0;
      stb_s2_r <= 1'b0;
    end
    else
    begin
      stb_s1_r <= strobe_in;
      stb_s2_r <= stb_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Edge history taken from the second stage only
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      sclk_d_r <= 1'b0;
    end
    else
    begin
      sclk_d_r <= sclk_s2_r;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      stb_d_r <= 1'b0;
    end
    else
    begin
      stb_d_r <= stb_s2_r;
    end
  end

  logic sclk_fall;
  logic stb_fall;

  // Clock edges count only while the strobe is high
  assign sclk_fall = sclk_d_r & ~sclk_s2_r & stb_s2_r;
  assign stb_fall = stb_d_r & ~stb_s2_r;

  // ----------------------------------------------------------------
  // Shift register and bit counter
  // ----------------------------------------------------------------
  logic [11:0] shift_r;
  logic [11:0] shift_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic word_done;

  assign shift_nxt = {shift_r[WORD_BITS-2:0], sdat_s2_r};
  assign bit_cnt_nxt = bit_cnt_r + 4'h1;
  assign word_done = sclk_fall && (bit_cnt_nxt == WORD_LAST);

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      shift_r <= SHIFT_RST;
    else if (sclk_fall)
      shift_r <= shift_nxt;
  end

  // Strobe low drops any partial word; a full word restarts the count
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      bit_cnt_r <= BIT_CNT_ZERO;
    else if (!stb_s2_r)
      bit_cnt_r <= BIT_CNT_ZERO;
    else if (word_done)
      bit_cnt_r <= BIT_CNT_ZERO;
    else if (sclk_fall)
      bit_cnt_r <= bit_cnt_nxt;
  end

  // ----------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------
  logic [1:0] word_type;
  logic is_data;
  logic is_ctrl;

  // Other type codes, such as all zeros, are ignored
  assign word_type = shift_nxt[TYPE_HI:TYPE_LO];
  assign is_data = word_done && (word_type == TYPE_DATA);
  assign is_ctrl = word_done && (word_type == TYPE_CTRL);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic mode_r;
  logic [3:0] rng_r;
  logic [3:0] si_r;
  logic act_r;

  // Single-buffered mode can be set but never cleared
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      mode_r <= MODE_RST;
    else if (is_ctrl)
      mode_r <= mode_r | shift_nxt[CTRL_MODE_POS];
  end

  // Range waits here until the next update event
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      rng_r <= RNG_RST;
    else if (is_ctrl)
      rng_r <= shift_nxt[CTRL_RNG_HI:CTRL_RNG_LO];
  end

  // Inhibit and activate bits act at once
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      si_r <= SI_RST;
    else if (is_ctrl)
      si_r <= shift_nxt[CTRL_SI_HI:CTRL_SI_LO];
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      act_r <= ACT_RST;
    else if (is_ctrl)
      act_r <= shift_nxt[CTRL_ACT_POS];
  end

  // ----------------------------------------------------------------
  // Update event
  // ----------------------------------------------------------------
  logic single_upd_r;
  logic update;
  logic single_word;
  logic mode_set_word;

  // The control word that selects single mode updates at its own end
  assign single_word = word_done && (mode_r == MODE_SINGLE);
  assign mode_set_word = is_ctrl && shift_nxt[CTRL_MODE_POS];

  // In single mode the word just received reaches the outputs
  // one cycle later, after its holding write has settled
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      single_upd_r <= 1'b0;
    else
      single_upd_r <= single_word || mode_set_word;
  end

  assign update = (mode_r == MODE_DOUBLE) ? stb_fall : single_upd_r;

  // ----------------------------------------------------------------
  // Applied range
  // ----------------------------------------------------------------
  // Range setting reaches the amplifiers only on update
  logic [3:0] gain_r;

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      gain_r <= RNG_RST;
    else if (update)
      gain_r <= rng_r;
  end

  // ----------------------------------------------------------------
  // Holding buffers and output codes
  // ----------------------------------------------------------------
  qdac_hold_buf u_hold_buf
  (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .wr_en_in(is_data),
    .wr_chan_in(shift_nxt[ADDR_HI:ADDR_LO]),
    .wr_code_in(shift_nxt[CODE_HI:CODE_LO]),
    .update_in(update),
    .code_a_out(output_channel_a_out),
    .code_b_out(output_channel_b_out),
    .code_c_out(output_channel_c_out),
    .code_d_out(output_channel_d_out)
  );

  // ----------------------------------------------------------------
  // Shutdown logic
  // ----------------------------------------------------------------
  // The activate pin is used raw so that it acts without a clock
  logic wake_all;

  assign wake_all = act_r & hw_activate_pin_in;

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CHAN; gc++)
    begin : g_active
      assign chan_active_out[gc] = si_r[gc] | wake_all;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  assign gain_double_out = gain_r;
  assign mode_single_out = mode_r;
  assign control_word_out = {mode_r, rng_r, si_r, act_r};

endmodule // qdac_ctrl

`default_nettype wire

// File: test/qdac_ctrl_chk.sv
// Port checks for the quad converter control block
`timescale 1ns/1ps
`default_nettype none
module qdac_ctrl_chk
(
  // Clock, reset and pins
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic strobe_in,
  input wire logic hw_activate_pin_in,
  // Outputs watched
  input wire logic [7:0] output_channel_a_out,
  input wire logic [7:0] output_channel_b_out,
  input wire logic [7:0] output_channel_c_out,
  input wire logic [7:0] output_channel_d_out,
  input wire logic [3:0] gain_double_out,
  input wire logic [3:0] chan_active_out,
  input wire logic mode_single_out,
  input wire logic [9:0] control_word_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  logic [31:0] codes;
  assign codes = {output_channel_a_out, output_channel_b_out,
    output_channel_c_out, output_channel_d_out};
  sequence s_dbl_end;
    !mode_single_out ##0 $fell(strobe_in);
  endsequence
  sequence s_quiet;
    strobe_in [*7] ##0 !mode_single_out;
  endsequence
  a_reset_ctrl: assert property (disable iff (1'b0) $fell(reset_in) |->
    control_word_out == 10'h1e0 && !mode_single_out)
    else $error("control word not at reset value");
  a_reset_out: assert property (disable iff (1'b0) $fell(reset_in) |->
    codes == 32'h0 && gain_double_out == 4'hf && chan_active_out == 4'h0)
    else $error("outputs not at reset value");
  a_active_map: assert property (chan_active_out ==
    (control_word_out[4:1] | {4{control_word_out[0] & hw_activate_pin_in}}))
    else $error("channel active map wrong");
  a_mode_sticky: assert property (mode_single_out |=> mode_single_out)
    else $error("single mode cleared");
  a_mode_field: assert property (mode_single_out == control_word_out[9])
    else $error("mode output differs from register");
  a_dbl_hold: assert property (s_quiet |-> $stable(codes) &&
    $stable(gain_double_out))
    else $error("output moved while strobe high");
  a_dbl_apply: assert property (s_dbl_end |-> ##[3:8]
    gain_double_out == control_word_out[8:5])
    else $error("range not applied at strobe fall");
  a_single_apply: assert property (mode_single_out &&
    $changed(control_word_out) |-> ##[1:3]
    gain_double_out == control_word_out[8:5])
    else $error("range not applied per word");
endmodule // qdac_ctrl_chk
`default_nettype wire

// File: test/qdac_host_mdl.sv
// Host model driving the serial link pins
`timescale 1ns/1ps
`default_nettype none
module qdac_host_mdl
(
  // Clock
  input wire logic mclk_in,
  // Serial link pins
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic strobe_out
);
  initial
  begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    strobe_out = 1'b0;
  end
  task automatic half();
    repeat (8) @(posedge mclk_in);
  endtask
  // Opens or closes a frame; the clock rests low between frames
  task automatic frame(input logic en);
    half();
    strobe_out <= en;
    half();
  endtask
  // Twelve bits MSB first, data stable across each fall
  task automatic word(input logic [11:0] w);
    for (int i = 11; i >= 0; i--)
    begin
      ser_data_out <= w[i];
      ser_clk_out <= 1'b1;
      half();
      ser_clk_out <= 1'b0;
      half();
    end
    ser_data_out <= ~w[0];
  endtask
endmodule // qdac_host_mdl
`default_nettype wire

// File: test/qdac_ctrl_test.sv
// Self-checking bench for the quad converter control block
`timescale 1ns/1ps
`default_nettype none
module qdac_ctrl_test;
  import qdac_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic hw = 1'b0;
  logic sclk, sdat, stb, mode;
  logic [7:0] ca, cb, cc, cd, r;
  logic [3:0] gain, act;
  logic [9:0] ctrl, cw;
  logic [7:0] ex [4];
  int errors = 0;
  int samples_checked = 0;
  always #2 mclk_in = ~mclk_in;
  qdac_host_mdl i_qdac_host_mdl (.mclk_in(mclk_in), .ser_clk_out(sclk),
    .ser_data_out(sdat), .strobe_out(stb));
  qdac_ctrl i_qdac_ctrl (.mclk_in(mclk_in), .reset_in(reset_in),
    .ser_clk_in(sclk), .ser_data_in(sdat), .strobe_in(stb),
    .hw_activate_pin_in(hw), .output_channel_a_out(ca),
    .output_channel_b_out(cb), .output_channel_c_out(cc),
    .output_channel_d_out(cd), .gain_double_out(gain),
    .chan_active_out(act), .mode_single_out(mode), .control_word_out(ctrl));
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [3:0] exp_act(input logic [9:0] c, input logic h);
    return c[4:1] | {4{c[0] & h}};
  endfunction
  task automatic wrd(input logic [1:0] t, input logic [9:0] v);
    i_qdac_host_mdl.word({t, v});
    repeat (10) @(posedge mclk_in);
  endtask
  task automatic chk_codes();
    chk({ca, cb, cc, cd}, {ex[0], ex[1], ex[2], ex[3]});
  endtask
  initial
  begin
    repeat (100000) @(posedge mclk_in);
    errors++;
    test_done();
  end
  initial
  begin
    void'($urandom(43231));
    ex = '{default: 8'h00};
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    repeat (10) @(posedge mclk_in);
    chk(ctrl, 10'h1e0);
    chk({gain, act, mode}, 9'h1e0);
    chk_codes();
    i_qdac_host_mdl.frame(1'b1);
    for (int i = 3; i >= 0; i--)
    begin
      r = 8'($urandom());
      ex[i] = r;
      wrd(TYPE_DATA, {2'(i), ~r});
      wrd(TYPE_DATA, {2'(i), r});
    end
    cw = 10'h0a7;
    wrd(TYPE_CTRL, cw);
    chk(ctrl, cw);
    chk({gain, ca, cb, cc, cd}, 36'hf00000000);
    i_qdac_host_mdl.frame(1'b0);
    repeat (10) @(posedge mclk_in);
    chk_codes();
    chk(gain, 4'h5);
    wrd(TYPE_DATA, 10'h05a);
    chk_codes();
    i_qdac_host_mdl.frame(1'b1);
    wrd(2'h0, 10'h000);
    chk(ctrl, cw);
    for (int i = 0; i < 8; i++)
    begin
      cw = {5'h05, i[2] ? 4'h9 : 4'h0, i[1]};
      hw <= i[0];
      wrd(TYPE_CTRL, cw);
      chk(act, exp_act(cw, hw));
    end
    @(posedge mclk_in);
    hw <= ~hw;
    #1;
    chk(act, exp_act(cw, hw));
    wrd(TYPE_CTRL, 10'h35e);
    chk(mode, 1'b1);
    chk(gain, 4'ha);
    r = 8'($urandom());
    ex[2] = r;
    wrd(TYPE_DATA, {2'd2, r});
    chk_codes();
    wrd(TYPE_CTRL, 10'h0e0);
    chk({ctrl[9], gain}, 5'h17);
    i_qdac_host_mdl.frame(1'b0);
    test_done();
  end
endmodule // qdac_ctrl_test
bind qdac_ctrl qdac_ctrl_chk i_qdac_ctrl_chk (.mclk_in(mclk_in),
  .reset_in(reset_in), .strobe_in(strobe_in),
  .hw_activate_pin_in(hw_activate_pin_in),
  .output_channel_a_out(output_channel_a_out),
  .output_channel_b_out(output_channel_b_out),
  .output_channel_c_out(output_channel_c_out),
  .output_channel_d_out(output_channel_d_out),
  .gain_double_out(gain_double_out), .chan_active_out(chan_active_out),
  .mode_single_out(mode_single_out), .control_word_out(control_word_out));
`default_nettype wire
